//--- rtl/fss_shaping_seq.sv
// fsk shaping sequencer: frequency profile stepping and pa turn-on ramp
//
// Overview of operation
// - pa level constant after ramp completes
// - pa rises one increment per interval
// - twenty samples, nineteen increments, from base frequency
// - interval counts 0.3125 us ticks from register
// - increments are in synthesizer resolution units
// - frequency held after last increment
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`include "fss_map.svh"

module fss_shaping_seq (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [15:0]  reg_rdata,
    input  wire logic         tx_data,
    output logic      [15:0]  freq_offset,
    output logic      [7:0]   pa_level,
    output logic              tx_active
);
    import fss_pkg::*;

    fss_core_t q;         // registered state
    fss_core_t d;         // next state
    logic      step_en;   // one pulse per time-step interval

    // ==========================================
    // helpers

    // offset moved by one increment; clamps so a sweep reversed mid-way
    // can never wrap past the deviation limits
    function automatic logic [15:0] fss_move(
        input logic [15:0] cur,
        input logic [7:0]  inc,
        input logic        up
    );
        logic [16:0] sum;
        sum = {1'b0, cur} + {9'd0, inc};
        if (up) begin
            fss_move = sum[16] ? 16'hffff : sum[15:0];
        end else begin
            fss_move = (cur < {8'd0, inc}) ? 16'h0000 : cur - {8'd0, inc};
        end
    endfunction

    // next pa level on a ramp step, clamped at the final level
    function automatic logic [7:0] fss_ramp(
        input logic [7:0] cur,
        input logic [7:0] stp,
        input logic [7:0] fin
    );
        logic [8:0] sum;
        sum = {1'b0, cur} + {1'b0, stp};
        if (stp == 8'd0 || sum >= {1'b0, fin}) begin
            fss_ramp = fin;
        end else begin
            fss_ramp = sum[7:0];
        end
    endfunction

    // shape word decode, shared by the write and read paths
    function automatic logic fss_is_shape(
        input logic [7:0] addr
    );
        fss_is_shape = (addr >= `FSS_OFS_SHAPE0) && (addr <= `FSS_OFS_SHAPE18);
    endfunction

    // position of a shape word inside the increment table
    function automatic logic [4:0] fss_shape_idx(
        input logic [7:0] addr
    );
        logic [7:0] rel;
        rel = addr - `FSS_OFS_SHAPE0;
        fss_shape_idx = rel[4:0];
    endfunction

    // ==========================================
    // interval timebase, runs only while transmitting
    fss_tick_gen u_tick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (q.en),
        .tstep   (q.tstep),
        .step_en (step_en)
    );

    // ==========================================
    // next state
    always_comb begin
        logic data_new;   // settled data level after the synchroniser
        logic edge_seen;  // data transition accepted this cycle
        data_new = q.data_lvl;
        edge_seen = 1'b0;
        d = q;
        // data pin: three flops, change accepted once last two agree
        d.sync = {q.sync[1:0], tx_data};
        if (q.sync[1] == q.sync[2]) begin
            data_new = q.sync[2];
        end
        d.data_lvl = data_new;

        // ----- register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `FSS_OFS_CTRL:     d.en = reg_wdata[`FSS_CTRL_EN_BIT];
                `FSS_OFS_TSTEP:    d.tstep = reg_wdata[7:0];
                `FSS_OFS_PA_FINAL: d.pa_final = reg_wdata[7:0];
                `FSS_OFS_PA_STEP:  d.pa_step = reg_wdata[7:0];
                default: begin
                    // shape words; read-only and unmapped offsets ignored
                    if (fss_is_shape(reg_addr)) begin
                        d.shape[fss_shape_idx(reg_addr)] = reg_wdata[7:0];
                    end
                end
            endcase
        end

        // ----- register reads, data valid the next cycle only
        d.rd_data = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `FSS_OFS_CTRL:     d.rd_data = {15'd0, q.en};
                `FSS_OFS_TSTEP:    d.rd_data = {8'd0, q.tstep};
                `FSS_OFS_PA_FINAL: d.rd_data = {8'd0, q.pa_final};
                `FSS_OFS_PA_STEP:  d.rd_data = {8'd0, q.pa_step};
                `FSS_OFS_STATUS: begin
                    d.rd_data[`FSS_STAT_RAMP_BIT]  = q.ramp_done;
                    d.rd_data[`FSS_STAT_SWEEP_BIT] = (q.state == FSS_SWEEP);
                    d.rd_data[`FSS_STAT_DATA_BIT]  = q.data_lvl;
                    d.rd_data[`FSS_STAT_DIR_BIT]   = q.dir;
                    d.rd_data[`FSS_STAT_IDX_LSB +: 5] = q.idx;
                end
                `FSS_OFS_FREQ:     d.rd_data = q.offset;
                default: begin
                    // unmapped offsets read as zero
                    if (fss_is_shape(reg_addr)) begin
                        d.rd_data = {8'd0, q.shape[fss_shape_idx(reg_addr)]};
                    end
                end
            endcase
        end

        // ----- sequencer
        edge_seen = (data_new != q.data_lvl);
        unique case (q.state)
            FSS_IDLE: begin
                // start of transmission: base frequency, pa off
                if (q.en) begin
                    d.offset = 16'h0000;
                    d.pa = 8'd0;
                    d.ramp_done = 1'b0;
                    d.idx = 5'd0;
                    d.dir = data_new;
                    // a high data level starts an upward sweep through the 19 increments, a low one holds at base
                    d.state = data_new ? FSS_SWEEP : FSS_HOLD;
                end
            end
            FSS_SWEEP: begin
                if (step_en) begin
                    d.offset = fss_move(q.offset, q.shape[q.idx], q.dir);
                    d.idx = q.idx + 5'd1;
                    if (q.idx == `FSS_LAST_IDX) begin
                        d.state = FSS_HOLD;
                    end
                end
            end
            FSS_HOLD: begin
                // frequency stays put until the next transition
                d.offset = q.offset;
            end
        endcase

        // a new transition restarts the profile from where it stands,
        // so a short bit never leaves the tone stranded mid-sweep
        if (q.state != FSS_IDLE && edge_seen) begin
            d.dir = data_new;
            d.idx = 5'd0;
            d.state = FSS_SWEEP;
            if (step_en && q.state == FSS_SWEEP) begin
                d.offset = q.offset;   // the step now due belongs to the old sweep
            end
        end

        // ----- pa turn-on ramp
        if (q.state != FSS_IDLE && !q.ramp_done && step_en) begin
            d.pa = fss_ramp(q.pa, q.pa_step, q.pa_final);
            d.ramp_done = (fss_ramp(q.pa, q.pa_step, q.pa_final) == q.pa_final);
        end else if (q.ramp_done) begin
            d.pa = q.pa;
        end

        // disabling ends the transmission at once
        if (!q.en) begin
            d.state = FSS_IDLE;
            d.pa = 8'd0;
            d.offset = 16'h0000;
            d.ramp_done = 1'b0;
            d.idx = 5'd0;
        end

        // activity flag registered so tx_active leaves a flop directly
        d.active = (d.state != FSS_IDLE);
    end

    // ==========================================
    // state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // outputs, all straight from flops
    assign reg_rdata   = q.rd_data;
    assign freq_offset = q.offset;
    assign pa_level    = q.pa;
    assign tx_active   = q.active;

    // ==========================================
    // checks

    // settled data transition while transmitting
    sequence s_edge;
        q.state != FSS_IDLE && q.en && (d.data_lvl != q.data_lvl);
    endsequence

    // sweep begins afresh in the new direction
    sequence s_restart;
        q.state == FSS_SWEEP && q.idx == 5'd0 && q.dir == q.data_lvl;
    endsequence

    chk_pa_held: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.ramp_done && q.en && d.en) |=> $stable(q.pa) && q.pa == $past(q.pa_final))
        else $error("pa level moved after ramp end");

    chk_pa_ramp_step: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.en && q.state != FSS_IDLE && !q.ramp_done && step_en && !reg_wr) |=>
            q.pa == fss_ramp($past(q.pa), q.pa_step, q.pa_final))
        else $error("pa ramp step wrong");

    chk_start_base: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == FSS_IDLE && q.en && d.en) |=> q.offset == 16'h0000 && q.pa == 8'd0)
        else $error("transmission did not start at base frequency");

    chk_sweep_len: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == FSS_SWEEP && step_en && q.idx == `FSS_LAST_IDX && q.en && d.en
            && !(d.data_lvl != q.data_lvl)) |=> q.state == FSS_HOLD)
        else $error("sweep did not end after nineteen increments");

    chk_freq_inc: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == FSS_SWEEP && step_en && q.en && d.en && !(d.data_lvl != q.data_lvl)
            && !reg_wr) |=>
            q.offset == fss_move($past(q.offset), q.shape[$past(q.idx)], q.dir))
        else $error("frequency increment wrong");

    chk_freq_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == FSS_HOLD && q.en && d.en) |=> $stable(q.offset))
        else $error("frequency moved while holding");

    chk_reverse: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_edge ##1 q.en |-> s_restart)
        else $error("transition did not restart reversed sweep");

    // data level follows the pin only once the last two stages agree
    chk_sync_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.sync[1] != q.sync[2]) |=> $stable(q.data_lvl))
        else $error("data level moved before the synchroniser settled");

    chk_sync_take: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.sync[1] == q.sync[2]) |=> q.data_lvl == $past(q.sync[2]))
        else $error("settled data level not taken");

    // the profile never runs past its last increment
    chk_idx_bound: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.state == FSS_SWEEP) |-> q.idx <= `FSS_LAST_IDX)
        else $error("sweep index beyond last increment");

    // disable returns pa, frequency and activity to rest
    chk_stop_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !q.en |=> q.state == FSS_IDLE && q.pa == 8'd0 && q.offset == 16'h0000 && !q.active)
        else $error("disable did not clear the transmission");

    // read data stand only in the cycle after a read strobe
    chk_rd_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !reg_rd |=> q.rd_data == 16'h0000)
        else $error("read data stood outside its cycle");

endmodule

//--- rtl/fss_map.svh
// register offsets, field positions, reset values and timing counts of the shaping sequencer
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

// ==========================================
// register offsets (word index on reg_addr)
`define FSS_OFS_CTRL      8'h00
`define FSS_OFS_TSTEP     8'h01
`define FSS_OFS_PA_FINAL  8'h02
`define FSS_OFS_PA_STEP   8'h03
`define FSS_OFS_STATUS    8'h04
`define FSS_OFS_FREQ      8'h05
`define FSS_OFS_SHAPE0    8'h10
`define FSS_OFS_SHAPE18   8'h22

// ==========================================
// field positions
`define FSS_CTRL_EN_BIT     0
`define FSS_STAT_RAMP_BIT   0
`define FSS_STAT_SWEEP_BIT  1
`define FSS_STAT_DATA_BIT   2
`define FSS_STAT_DIR_BIT    3
`define FSS_STAT_IDX_LSB    8

// ==========================================
// reset values
`define FSS_RST_TSTEP     8'h00
`define FSS_RST_PA_FINAL  8'h00
`define FSS_RST_PA_STEP   8'h00

// ==========================================
// timing: one base tick is 0.3125 us, clock period is 100 ns
`define FSS_TICK_PS       312500
`define FSS_CLK_PS        100000
`define FSS_TICK_CYC_MIN  (`FSS_TICK_PS / `FSS_CLK_PS)
`define FSS_TICK_CYC_MAX  ((`FSS_TICK_PS + `FSS_CLK_PS - 1) / `FSS_CLK_PS)

// ==========================================
// profile shape
`define FSS_NUM_STEPS     19
`define FSS_LAST_IDX      5'd18

`endif

//--- rtl/fss_pkg.sv
// types shared by the shaping sequencer modules
package fss_pkg;

    // ==========================================
    // sequencer states
    typedef enum logic [1:0] {
        FSS_IDLE,
        FSS_SWEEP,
        FSS_HOLD
    } fss_state_t;

    // ==========================================
    // timebase state
    typedef struct packed {
        logic [18:0] acc;     // picosecond phase accumulator
        logic [7:0]  cnt;     // ticks counted inside one interval
        logic        step;    // one-cycle interval pulse
    } fss_tick_t;

    // ==========================================
    // core state
    typedef struct packed {
        fss_state_t       state;
        logic [2:0]       sync;      // data pin synchroniser, bit0 first
        logic             data_lvl;  // accepted data level
        logic             dir;       // 1 sweeps up, 0 sweeps down
        logic [4:0]       idx;       // next increment to apply
        logic [15:0]      offset;    // above base_frequency, synth units
        logic [7:0]       pa;        // power amplifier level
        logic             ramp_done; // pa has reached its final level
        logic             en;        // transmission enabled
        logic [7:0]       tstep;     // base ticks per interval
        logic [7:0]       pa_final;
        logic [7:0]       pa_step;
        logic [18:0][7:0] shape;     // the 19 increments
        logic [15:0]      rd_data;
        logic             active;    // not idle, registered copy for tx_active
    } fss_core_t;

endpackage

//--- rtl/fss_tick_gen.sv
// base-tick divider and time-step interval counter
`timescale 1ns/1ns

module fss_tick_gen (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [7:0] tstep,
    output logic            step_en
);
    import fss_pkg::*;

    fss_tick_t q;   // registered state
    fss_tick_t d;   // next state

    // ticks per interval; a zero setting acts as one tick so the
    // timebase can never stall on an unprogrammed register
    function automatic logic [7:0] fss_ticks(
        input logic [7:0] t
    );
        fss_ticks = (t == 8'd0) ? 8'd1 : t;
    endfunction

    // ==========================================
    // next state
    // 10 MHz is not a whole multiple of 0.3125 us, so ticks fall 3 or 4
    // cycles apart and average out exactly over every 8 ticks
    always_comb begin
        logic [19:0] sum;
        logic [7:0]  lim;
        sum = 20'd0;
        lim = 8'd0;
        d = q;
        d.step = 1'b0;
        if (!run) begin
            // idle: restart the interval so the first step is a full one
            d.acc = 19'd0;
            d.cnt = 8'd0;
        end else begin
            sum = {1'b0, q.acc} + 20'(`FSS_CLK_PS);
            lim = fss_ticks(tstep);
            if (sum >= 20'(`FSS_TICK_PS)) begin
                d.acc = 19'(sum - 20'(`FSS_TICK_PS));
                if (q.cnt + 8'd1 >= lim) begin
                    d.cnt = 8'd0;
                    d.step = 1'b1;
                end else begin
                    d.cnt = q.cnt + 8'd1;
                end
            end else begin
                d.acc = sum[18:0];
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign step_en = q.step;

    // ==========================================
    // interval length check: N ticks take 3N..4N cycles
    logic [11:0] gap_q;   // cycles since last step
    logic        seen_q;  // a step has occurred in this run

    // helper counter only read by the check below
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            gap_q  <= 12'd0;
            seen_q <= 1'b0;
        end else if (q.step) begin
            gap_q  <= 12'd1;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 12'd1;
        end
    end

    chk_step_spacing: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (q.step && seen_q && run && $stable(tstep)) |->
            (gap_q >= 12'(`FSS_TICK_CYC_MIN) * 12'(fss_ticks(tstep))) &&
            (gap_q <= 12'(`FSS_TICK_CYC_MAX) * 12'(fss_ticks(tstep))))
        else $error("time-step interval has wrong length");

endmodule

//--- tb/fss_cfg_model.sv
// configuration software model: register bus master and transmit data source
`timescale 1ns/1ns
`include "fss_map.svh"

module fss_cfg_model (
    input  wire logic        sys_clk,
    output logic      [7:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata,
    output logic             tx_data
);
    // ==========================================
    // gaussian profile, 19 steps summing to 408 synth units (~100 khz)
    localparam logic [7:0] SHAPE [19] = '{8'h04, 8'h09, 8'h0f, 8'h14, 8'h18, 8'h1b,
        8'h1d, 8'h1f, 8'h1e, 8'h1f, 8'h1e, 8'h1f, 8'h1d, 8'h1b, 8'h18, 8'h14, 8'h0f,
        8'h09, 8'h03};
    // 3 ticks = 0.9375 us, under a twentieth of a 20 us bit
    localparam logic [7:0] TSTEP = 8'h03;

    // idle bus and data level at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        tx_data   = 1'b0;
    end

    // one-cycle write; released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // one-cycle read; data taken mid-cycle of the answer cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    // data pin changes just after an edge
    task automatic set_data(input logic v);
        @(posedge sys_clk);
        tx_data <= v;
    endtask

    // interval and all 19 increments, always written as a full set
    task automatic load_profile();
        wr(`FSS_OFS_TSTEP, {8'h00, TSTEP});
        for (int i = 0; i < 19; i++) begin
            wr(`FSS_OFS_SHAPE0 + 8'(i), {8'h00, SHAPE[i]});
        end
    endtask
endmodule

//--- tb/tb_fsk_shaping_sequencer.sv
// self-checking bench for the fsk shaping sequencer
`timescale 1ns/1ns
`include "fss_map.svh"

`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module tb_fsk_shaping_sequencer;
    import fss_pkg::*;

    // ==========================================
    // signals
    logic        sys_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        tx_data;
    logic [15:0] freq_offset;
    logic [7:0]  pa_level;
    logic        tx_active;
    int          error_cnt;
    int          total_checks;

    // 10 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    fss_shaping_seq dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_data(tx_data), .freq_offset(freq_offset), .pa_level(pa_level),
        .tx_active(tx_active));

    fss_cfg_model cfg (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data));

    // ==========================================
    // helpers
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cycles until pa or offset moves; bounded so a stuck sequencer ends the run
    task automatic wait_chg(input bit on_pa, output int n);
        logic [15:0] v0;
        v0 = on_pa ? {8'h00, pa_level} : freq_offset;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((on_pa ? {8'h00, pa_level} : freq_offset) === v0 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            print_verdict();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [15:0] d;
        logic [7:0]  ofs [6] = '{`FSS_OFS_CTRL, `FSS_OFS_TSTEP, `FSS_OFS_PA_FINAL,
            `FSS_OFS_PA_STEP, `FSS_OFS_FREQ, 8'h0f};
        `CHK(tx_active, 1'b0)
        `CHK(pa_level, 8'h00)
        `CHK(freq_offset, 16'h0000)
        for (int i = 0; i < 6; i++) begin
            cfg.rd(ofs[i], d);
            `CHK(d, 16'h0000)
        end
    endtask

    // widths, read-only place, then the profile
    task automatic t_regs();
        logic [15:0] d;
        cfg.wr(`FSS_OFS_TSTEP, 16'hab07);
        cfg.rd(`FSS_OFS_TSTEP, d);
        `CHK(d, 16'h0007)
        cfg.wr(`FSS_OFS_FREQ, 16'h1234);
        cfg.rd(`FSS_OFS_FREQ, d);
        `CHK(d, 16'h0000)
        cfg.wr(`FSS_OFS_PA_FINAL, 16'h0014);
        cfg.wr(`FSS_OFS_PA_STEP, 16'h0006);
        cfg.load_profile();
        cfg.rd(`FSS_OFS_SHAPE18, d);
        `CHK(d, 16'h0003)
    endtask

    // data low at enable: pa ramps 6,12,18 then clamps at 20 and stays
    task automatic t_ramp();
        int n;
        bit bad;
        cfg.wr(`FSS_OFS_CTRL, 16'h0001);
        repeat (2) @(negedge sys_clk);
        `CHK(tx_active, 1'b1)
        for (int k = 1; k <= 4; k++) begin
            wait_chg(1'b1, n);
            `CHK(pa_level, 8'((k * 6 > 20) ? 20 : k * 6))
            if (k > 1) `CHK(n >= 9 && n <= 12, 1'b1)
        end
        bad = 1'b0;
        repeat (80) begin
            @(negedge sys_clk);
            if (pa_level !== 8'd20 || freq_offset !== 16'h0000) bad = 1'b1;
        end
        `CHK(bad, 1'b0)
    endtask

    // sweep up or down, as given, through all 19 increments, then a hold at the end value
    task automatic t_sweep(input logic up);
        int n;
        int cum;
        bit bad;
        logic [15:0] d;
        cum = 0;
        cfg.set_data(up);
        @(negedge sys_clk);
        for (int i = 0; i < 19; i++) begin
            wait_chg(1'b0, n);
            cum += cfg.SHAPE[i];
            `CHK(freq_offset, 16'(up ? cum : 408 - cum))
            if (i > 0) `CHK(n >= 9 && n <= 12, 1'b1)
        end
        bad = 1'b0;
        repeat (60) begin
            @(negedge sys_clk);
            if (freq_offset !== 16'(up ? 408 : 0) || pa_level !== 8'd20) bad = 1'b1;
        end
        `CHK(bad, 1'b0)
        cfg.rd(`FSS_OFS_STATUS, d);
        `CHK(d & 16'h000f, 16'(up ? 16'h000d : 16'h0001))
        cfg.rd(`FSS_OFS_FREQ, d);
        `CHK(d, 16'(up ? 408 : 0))
    endtask

    // disable drops everything, ignores data while off; data high at enable sweeps up
    task automatic t_disable();
        int n;
        cfg.set_data(1'b1);
        cfg.wr(`FSS_OFS_CTRL, 16'h0000);
        repeat (2) @(negedge sys_clk);
        `CHK({tx_active, pa_level, freq_offset}, 25'h0)
        repeat (6) @(negedge sys_clk);
        `CHK({tx_active, pa_level, freq_offset}, 25'h0)
        cfg.wr(`FSS_OFS_CTRL, 16'h0001);
        repeat (2) @(negedge sys_clk);
        `CHK({tx_active, pa_level, freq_offset}, 25'h1000000)
        wait_chg(1'b0, n);
        `CHK(freq_offset, {8'h00, cfg.SHAPE[0]})
        `CHK(pa_level, 8'h06)
    endtask

    // ==========================================
    // main sequence
    initial begin
        rst_n        = 1'b0;
        error_cnt    = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_regs();
        t_ramp();
        t_sweep(1'b1);
        t_sweep(1'b0);
        t_disable();
        print_verdict();
    end
endmodule
